// >>> design/lpst_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
module lpst_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,      // Clock
  input  wire logic             srst,     // Sync reset
  input  wire logic [WIDTH-1:0] inData,   // Write data
  input  wire logic             inValid,  // Write valid
  output logic                  inReady,  // Not full
  output logic      [WIDTH-1:0] outData,  // Head data
  output logic                  outValid, // Not empty
  input  wire logic             outReady  // Drain
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wrPtr_ff;
  logic [AW-1:0]    rdPtr_ff;
  logic [AW:0]      count_ff;
  logic             doPush;
  logic             doPop;
  assign inReady  = (count_ff != (AW+1)'(DEPTH));
  assign outValid = (count_ff != '0);
  assign outData  = mem_ff[rdPtr_ff];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem_ff[wrPtr_ff] <= inData;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (doPush) begin
        wrPtr_ff <= (wrPtr_ff == AW'(DEPTH-1)) ? '0 : wrPtr_ff + 1'b1;
      end
      if (doPop) begin
        rdPtr_ff <= (rdPtr_ff == AW'(DEPTH-1)) ? '0 : rdPtr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end
endmodule : lpst_fifo

// >>> design/lpst_screen_timing.sv
// LCD panel screen timing core with AXI4-Lite registers
`timescale 1ns/10ps
module lpst_screen_timing #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic        clk,           // 10 MHz clock
  input  wire logic        srst,          // Sync reset, high
  input  wire logic [7:0]  s_axi_awaddr,  // Write address
  input  wire logic        s_axi_awvalid, // Write address valid
  output logic             s_axi_awready, // Write address ready
  input  wire logic [31:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]  s_axi_wstrb,   // Byte strobes
  input  wire logic        s_axi_wvalid,  // Write data valid
  output logic             s_axi_wready,  // Write data ready
  output logic [1:0]       s_axi_bresp,   // Write response
  output logic             s_axi_bvalid,  // Write response valid
  input  wire logic        s_axi_bready,  // Write response ready
  input  wire logic [7:0]  s_axi_araddr,  // Read address
  input  wire logic        s_axi_arvalid, // Read address valid
  output logic             s_axi_arready, // Read address ready
  output logic [31:0]      s_axi_rdata,   // Read data
  output logic [1:0]       s_axi_rresp,   // Read response
  output logic             s_axi_rvalid,  // Read valid
  input  wire logic        s_axi_rready,  // Read ready
  input  wire logic [23:0] pixData,       // Overlay pixel stream
  input  wire logic        pixValid,      // Overlay pixel valid
  input  wire logic        pixCover,      // Pixel covered by a window
  output logic             pixReady,      // FIFO can take a pixel
  output lpst_pkg::lpst_panel_t panel     // Panel pins
);
  import lpst_pkg::*;

  logic [31:0] screen_ff, back_ff, horiz_ff, vert_ff, clock_ff;
  logic        awHeld_ff, wHeld_ff, bvalid_ff, rvalid_ff, bErr_ff, rErr_ff;
  logic [7:0]  awAddr_ff;
  logic [31:0] wData_ff, rdata_ff;
  logic [3:0]  wStrb_ff;

  // Write channel: address and data taken independently
  assign s_axi_awready = !awHeld_ff && !bvalid_ff;
  assign s_axi_wready  = !wHeld_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bErr_ff ? RESP_SLVERR : RESP_OKAY;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rErr_ff ? RESP_SLVERR : RESP_OKAY;

  logic doWrite;
  assign doWrite = awHeld_ff && wHeld_ff && !bvalid_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      awHeld_ff <= 1'b0;
      wHeld_ff  <= 1'b0;
      awAddr_ff <= '0;
      wData_ff  <= '0;
      wStrb_ff  <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_ff <= 1'b0;
      end
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb,
                                        input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r & mask;
  endfunction : merge

  logic addrHit;
  assign addrHit = (awAddr_ff == ADDR_SCREEN) || (awAddr_ff == ADDR_BACK) ||
                   (awAddr_ff == ADDR_HORIZ) || (awAddr_ff == ADDR_VERT) ||
                   (awAddr_ff == ADDR_CLOCK);

  logic [31:0] screenNew;
  logic [31:0] nxt_screen;
  assign screenNew = merge(screen_ff, wData_ff, wStrb_ff, SCREEN_MASK);
  always_comb begin
    nxt_screen = screen_ff;
    if (screen_ff[EN_BIT]) begin
      // While running only force-white, polarity and enable follow writes
      nxt_screen[WP_BIT] = screenNew[WP_BIT];
      nxt_screen[FW_BIT] = screenNew[FW_BIT];
      nxt_screen[EN_BIT] = screenNew[EN_BIT];
    end else begin
      nxt_screen = screenNew;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      screen_ff <= REG_RESET;
      back_ff   <= REG_RESET;
      horiz_ff  <= REG_RESET;
      vert_ff   <= REG_RESET;
      clock_ff  <= REG_RESET;
    end else if (doWrite) begin
      unique case (awAddr_ff)
        ADDR_SCREEN: screen_ff <= nxt_screen;
        ADDR_BACK:   back_ff <= merge(back_ff, wData_ff, wStrb_ff, BACK_MASK);
        ADDR_HORIZ:  horiz_ff <= merge(horiz_ff, wData_ff, wStrb_ff,
                                       TIMING_MASK);
        ADDR_VERT:   vert_ff <= merge(vert_ff, wData_ff, wStrb_ff,
                                      TIMING_MASK);
        ADDR_CLOCK:  clock_ff <= merge(clock_ff, wData_ff, wStrb_ff,
                                       CLOCK_MASK);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bvalid_ff <= 1'b0;
      bErr_ff   <= 1'b0;
    end else if (doWrite) begin
      bvalid_ff <= 1'b1;
      bErr_ff   <= !addrHit;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read channel: data stand from the edge after the address is taken
  always_ff @(posedge clk) begin
    if (srst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rErr_ff   <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rErr_ff   <= 1'b0;
      unique case (s_axi_araddr)
        ADDR_SCREEN: rdata_ff <= screen_ff;
        ADDR_BACK:   rdata_ff <= back_ff;
        ADDR_HORIZ:  rdata_ff <= horiz_ff;
        ADDR_VERT:   rdata_ff <= vert_ff;
        ADDR_CLOCK:  rdata_ff <= clock_ff;
        default: begin
          rdata_ff <= '0;
          rErr_ff  <= 1'b1;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Pixel clock divider
  logic        enable;
  logic [2:0]  kind;
  logic        isTft;
  logic [9:0]  divCnt_ff;
  logic        pclk_ff;
  logic        pixTick, tickDly_ff;
  assign enable = screen_ff[EN_BIT];
  assign kind   = screen_ff[KIND_HI:KIND_LO];
  assign isTft  = (kind == KIND_TFT);

  always_ff @(posedge clk) begin
    if (srst || !enable) begin
      divCnt_ff <= '0;
      pclk_ff   <= 1'b0;
    end else if (clock_ff[BYPASS_BIT]) begin
      pclk_ff <= !pclk_ff;
    end else if (divCnt_ff == clock_ff[DIV_HI:DIV_LO]) begin
      divCnt_ff <= '0;
      pclk_ff   <= !pclk_ff;
    end else begin
      divCnt_ff <= divCnt_ff + 10'h001;
    end
  end
  // Launch on the selected pclk edge
  logic pclkToggle;
  assign pclkToggle = clock_ff[BYPASS_BIT] ||
                      (divCnt_ff == clock_ff[DIV_HI:DIV_LO]);
  assign pixTick = enable && pclkToggle &&
                   (pclk_ff == clock_ff[INVERT_BIT]);
  // Horizontal and vertical sequencers
  lpst_phase_t hPh_ff, vPh_ff;
  logic [10:0] hCnt_ff, vCnt_ff;
  logic [10:0] hLimit, vLimit;
  logic        lineEnd;

  always_comb begin
    unique case (hPh_ff)
      PH_SYNC:   hLimit = {2'h0, horiz_ff[SYNC_HI:SYNC_LO]};
      PH_FRONT:  hLimit = {2'h0, horiz_ff[FRONT_HI:FRONT_LO]};
      PH_ACTIVE: hLimit = screen_ff[WIDTH_HI:WIDTH_LO];
      PH_BACK:   hLimit = {2'h0, horiz_ff[BACK_HI:BACK_LO]};
    endcase
  end

  always_comb begin
    unique case (vPh_ff)
      PH_SYNC:   vLimit = {2'h0, vert_ff[SYNC_HI:SYNC_LO]};
      PH_FRONT:  vLimit = {2'h0, vert_ff[FRONT_HI:FRONT_LO]};
      PH_ACTIVE: vLimit = screen_ff[HEIGHT_HI:HEIGHT_LO];
      PH_BACK:   vLimit = {2'h0, vert_ff[BACK_HI:BACK_LO]};
    endcase
  end

  assign lineEnd = pixTick && (hPh_ff == PH_BACK) && (hCnt_ff == hLimit);
  always_ff @(posedge clk) begin
    if (srst || !enable) begin
      hPh_ff  <= PH_SYNC;
      hCnt_ff <= '0;
    end else if (pixTick) begin
      if (hCnt_ff == hLimit) begin
        hCnt_ff <= '0;
        hPh_ff  <= lpst_phase_t'(hPh_ff + 2'h1);
      end else begin
        hCnt_ff <= hCnt_ff + 11'h001;
      end
    end
  end

  // STN skips vsync and back blank lines
  always_ff @(posedge clk) begin
    if (srst || !enable) begin
      vPh_ff  <= isTft ? PH_SYNC : PH_FRONT;
      vCnt_ff <= '0;
    end else if (!isTft && (vPh_ff == PH_SYNC)) begin
      vPh_ff <= PH_FRONT;
    end else if (lineEnd) begin
      if (vCnt_ff == vLimit) begin
        vCnt_ff <= '0;
        unique case (vPh_ff)
          PH_SYNC:   vPh_ff <= PH_FRONT;
          PH_FRONT:  vPh_ff <= PH_ACTIVE;
          PH_ACTIVE: vPh_ff <= isTft ? PH_BACK : PH_FRONT;
          PH_BACK:   vPh_ff <= PH_SYNC;
        endcase
      end else begin
        vCnt_ff <= vCnt_ff + 11'h001;
      end
    end
  end
  // Pixel FIFO, popped a clock after the tick; bit 24 marks cover
  logic        activePix;
  logic        inActive;
  logic [24:0] fifoOut;
  logic        fifoValid;
  assign inActive  = (hPh_ff == PH_ACTIVE) && (vPh_ff == PH_ACTIVE);
  assign activePix = tickDly_ff && inActive;

  lpst_fifo #(
    .WIDTH (25),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .srst     (srst),
    .inData   ({pixCover, pixData}),
    .inValid  (pixValid),
    .inReady  (pixReady),
    .outData  (fifoOut),
    .outValid (fifoValid),
    .outReady (activePix)
  );

  // Panel output register
  always_ff @(posedge clk) begin
    if (srst) begin
      panel      <= '0;
      tickDly_ff <= 1'b0;
    end else begin
      tickDly_ff   <= pixTick;
      panel.pclk   <= pclk_ff;
      panel.hsync  <= enable && (hPh_ff == PH_SYNC);
      panel.vsync  <= enable && isTft && (vPh_ff == PH_SYNC);
      panel.dataEn <= enable && inActive;
      if (screen_ff[FW_BIT]) begin
        panel.data <= {24{screen_ff[WP_BIT]}};
      end else if (activePix) begin
        panel.data <= (fifoValid && fifoOut[24]) ? fifoOut[23:0]
                                                 : back_ff[23:0];
      end else if (tickDly_ff) begin
        panel.data <= '0;
      end
    end
  end
endmodule : lpst_screen_timing

// >>> shared/lpst_pkg.sv
// Package for the LCD panel screen timing core
package lpst_pkg;
  localparam int unsigned CLK_FREQ_HZ = 10000000;
  localparam logic [7:0] ADDR_SCREEN = 8'h04;
  localparam logic [7:0] ADDR_BACK   = 8'h08;
  localparam logic [7:0] ADDR_HORIZ  = 8'h0C;
  localparam logic [7:0] ADDR_VERT   = 8'h10;
  localparam logic [7:0] ADDR_CLOCK  = 8'h14;
  localparam logic [31:0] REG_RESET  = 32'h0000_0000;
  localparam logic [31:0] SCREEN_MASK = 32'hBFFF_FFC7;
  localparam logic [31:0] BACK_MASK   = 32'h00FF_FFFF;
  localparam logic [31:0] TIMING_MASK = 32'h07FF_FFFF;
  localparam logic [31:0] CLOCK_MASK  = 32'h007F_FFFF;
  localparam int unsigned EN_BIT = 31;
  localparam int unsigned WIDTH_HI = 29;
  localparam int unsigned WIDTH_LO = 19;
  localparam int unsigned HEIGHT_HI = 18;
  localparam int unsigned HEIGHT_LO = 8;
  localparam int unsigned WP_BIT = 7;
  localparam int unsigned FW_BIT = 6;
  localparam int unsigned KIND_HI = 2;
  localparam int unsigned KIND_LO = 0;
  localparam int unsigned BACK_HI = 26;
  localparam int unsigned BACK_LO = 18;
  localparam int unsigned FRONT_HI = 17;
  localparam int unsigned FRONT_LO = 9;
  localparam int unsigned SYNC_HI = 8;
  localparam int unsigned SYNC_LO = 0;
  localparam int unsigned BYPASS_BIT = 19;
  localparam int unsigned INVERT_BIT = 17;
  localparam int unsigned DIV_HI = 9;
  localparam int unsigned DIV_LO = 0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] KIND_TFT    = 3'h0;
  localparam logic [2:0] KIND_CSTN   = 3'h1;
  localparam logic [2:0] KIND_DSTN   = 3'h2;
  localparam logic [2:0] KIND_M8STN  = 3'h3;
  localparam logic [2:0] KIND_M4STN  = 3'h4;
  typedef enum logic [1:0] {PH_SYNC, PH_FRONT, PH_ACTIVE, PH_BACK}
    lpst_phase_t;
  typedef struct packed {
    logic        hsync;
    logic        vsync;
    logic        dataEn;
    logic        pclk;
    logic [23:0] data;
  } lpst_panel_t;
endpackage : lpst_pkg

// >>> tb/lcd_panel_screen_timing_tb.sv
// Self-checking bench for the screen timing core
`timescale 1ns/10ps
module lcd_panel_screen_timing_tb;
  import lpst_pkg::*;
  logic clk = 0, srst = 1, awv = 0, wv = 0, bready = 0, arv = 0;
  logic rready = 0, pixValid = 0, pixCover = 1, inv = 0, tk;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rdv, ck, lfsr = 32'hBA7769DA, exp[5];
  logic [3:0]  wstrb = 0;
  logic [23:0] pixData = 0, pq[$];
  logic [1:0]  resp, bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, pixReady;
  lpst_panel_t panel;
  int bad_count = 0, checks_done = 0, hsW, frW, deW, bkW, lines, n;
  always #50 clk = ~clk;
  lpst_screen_timing #(.FIFO_DEPTH(16)) dut (.clk(clk), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pixData(pixData),
    .pixValid(pixValid), .pixCover(pixCover), .pixReady(pixReady),
    .panel(panel));
  lpst_panel_model pm (.clk(clk), .inv(inv), .panel(panel), .hsW(hsW),
    .frW(frW), .deW(deW), .bkW(bkW), .lines(lines));
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic hang;
    bad_count++;
    end_of_test();
  endtask : hang
  task automatic chk(input logic [31:0] got, input logic [31:0] ev);
    checks_done++;
    if (got !== ev) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, ev);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int  k = 0;
    logic ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    do begin
      @(negedge clk);
      ta = awv && awready;
      tw = wv && wready;
      tb = bvalid;
      resp = bresp;
      @(posedge clk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
      k++;
    end while (!tb && k < 50);
    bready <= 0;
    if (!tb) hang();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int  k = 0;
    logic ta, tb;
    @(posedge clk);
    araddr <= a;
    arv <= 1;
    rready <= 1;
    do begin
      @(negedge clk);
      ta = arv && arready;
      tb = rvalid;
      resp = rresp;
      rdv = rdata;
      @(posedge clk);
      if (ta) arv <= 0;
      k++;
    end while (!tb && k < 50);
    rready <= 0;
    if (!tb) hang();
  endtask : rd
  task automatic wm(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int i = a / 4 - 1;
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    m &= i == 0 ? SCREEN_MASK : i == 1 ? BACK_MASK : TIMING_MASK;
    if (i == 4) m &= CLOCK_MASK;
    if (i == 0 && exp[0][31]) m &= 32'h8000_00C0;
    exp[i] = (exp[i] & ~m) | (d & m);
    wr(a, d, s);
    chk(resp, RESP_OKAY);
  endtask : wm
  task automatic rc(input logic [7:0] a);
    rd(a);
    chk(rdv, exp[a / 4 - 1]);
  endtask : rc
  task automatic frames(input int k);
    int  c = 0;
    logic pv = 0;
    while (k > 0 && c < 20000) begin
      @(posedge clk);
      if (panel.vsync && !pv) k--;
      pv = panel.vsync;
      c++;
    end
    if (k > 0) hang();
  endtask : frames
  initial begin
    repeat (6) @(posedge clk);
    srst <= 0;
    for (int i = 0; i < 5; i++) exp[i] = REG_RESET;
    for (int i = 0; i < 5; i++) rc(8'(4 + 4 * i));
    wr(8'h00, 32'hFFFF_FFFF, 4'hF);
    chk(resp, RESP_SLVERR);
    rd(8'h18);
    chk(resp, RESP_SLVERR);
    chk(rdv, 32'h0000_0000);
    for (int i = 0; i < 12; i++) begin
      lfsr = nx(lfsr);
      wm(8'(4 + 4 * (lfsr[10:8] % 5)), lfsr, lfsr[15:12]);
    end
    for (int i = 0; i < 5; i++) rc(8'(4 + 4 * i));
    wm(ADDR_SCREEN, 32'h0, 4'hF);
    for (int k = 0; k < 5; k++) begin
      wm(ADDR_SCREEN, 32'(k), 4'hF);
      rc(ADDR_SCREEN);
    end
    wm(ADDR_SCREEN, 32'h0, 4'hF);
    wm(ADDR_HORIZ, 32'h0004_0602, 4'hF);
    wm(ADDR_VERT, 32'h0000_0200, 4'hF);
    n = 0;
    pixValid <= 1;
    do begin
      @(negedge clk);
      tk = pixReady;
      if (tk) pq.push_back(pixCover ? pixData : exp[1][23:0]);
      @(posedge clk);
      lfsr = nx(lfsr);
      if (tk) pixData <= lfsr[23:0];
      if (tk) pixCover <= lfsr[24];
      n += 32'(tk);
    end while (tk && n < 40);
    pixValid <= 0;
    chk(n, 16);
    for (int c = 0; c < 3; c++) begin
      ck = c == 0 ? 32'h0 : c == 1 ? 32'h0002_0001 : 32'h0008_0000;
      wm(ADDR_CLOCK, ck, 4'hF);
      inv <= c == 1;
      pm.q.delete();
      wm(ADDR_SCREEN, 32'h8020_0200, 4'hF);
      frames(3);
      chk(hsW, 3);
      chk(frW, 4);
      chk(deW, 5);
      chk(bkW, 2);
      chk(lines, 3);
      for (int i = 0; i < 20; i++)
        chk(pm.q[i], i < pq.size() ? pq[i] : exp[1][23:0]);
      pq.delete();
      if (c < 2) wm(ADDR_SCREEN, 32'h0, 4'hF);
    end
    for (int w = 1; w >= 0; w--) begin
      wm(ADDR_SCREEN, 32'h8070_0240 | 32'(w << 7), 4'hF);
      rc(ADDR_SCREEN);
      pm.q.delete();
      frames(2);
      chk(pm.q[0], {24{w[0]}});
      chk(panel.data, {24{w[0]}});
    end
    // Colour STN: lines must still carry pixels, frame sync must stay low
    wm(ADDR_SCREEN, 32'h0, 4'hF);
    wm(ADDR_SCREEN, 32'h8020_0201, 4'hF);
    n = 0;
    repeat (400) begin
      @(posedge clk);
      n += panel.vsync ? 1000 : 32'(panel.dataEn);
    end
    chk(32'(n > 0 && n < 1000), 32'h1);
    end_of_test();
  end
endmodule : lcd_panel_screen_timing_tb

// >>> tb/lpst_checker.sv
// Assertion checker bound to the screen timing core
`timescale 1ns/10ps
module lpst_checker (
  input wire logic        clk,           // Clock
  input wire logic        srst,          // Reset
  input wire logic        s_axi_awvalid, // AW valid
  input wire logic        s_axi_awready, // AW ready
  input wire logic        s_axi_wvalid,  // W valid
  input wire logic        s_axi_wready,  // W ready
  input wire logic        s_axi_bvalid,  // B valid
  input wire logic        s_axi_bready,  // B ready
  input wire logic        s_axi_arvalid, // AR valid
  input wire logic        s_axi_arready, // AR ready
  input wire logic        s_axi_rvalid,  // R valid
  input wire logic        s_axi_rready,  // R ready
  input wire lpst_pkg::lpst_panel_t panel // Panel pins
);
  import lpst_pkg::*;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence sWrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence sRdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence sNoPixel;
    !panel.dataEn [*2];
  endsequence
  sequence sNoSync;
    !panel.hsync [*2];
  endsequence
  AST_WR_ANSWER: assert property (sWrTaken |-> ##[1:3] s_axi_bvalid)
    else $error("write answer missing");
  AST_RD_ANSWER: assert property (sRdTaken |=> s_axi_rvalid)
    else $error("read answer missing");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  AST_HS_NO_DE: assert property (panel.hsync |-> !panel.dataEn)
    else $error("pixel during line sync");
  AST_VS_NO_DE: assert property (panel.vsync |-> !panel.dataEn)
    else $error("pixel during frame sync");
  AST_FRONT: assert property ($fell(panel.hsync) |-> sNoPixel)
    else $error("front blank too short");
  AST_BACK: assert property ($fell(panel.dataEn) |-> sNoSync)
    else $error("back blank too short");
endmodule : lpst_checker

bind lpst_screen_timing lpst_checker u_chk (
  .clk(clk), .srst(srst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .panel(panel)
);

// >>> tb/lpst_panel_model.sv
// Panel model measuring line phases and capturing active pixels
`timescale 1ns/10ps
module lpst_panel_model (
  input wire logic                  clk,   // Clock
  input wire logic                  inv,   // Launch on falling pclk
  input wire lpst_pkg::lpst_panel_t panel, // Panel pins
  output int                        hsW,   // Sync pixels
  output int                        frW,   // Front blank pixels
  output int                        deW,   // Active pixels
  output int                        bkW,   // Back blank pixels
  output int                        lines  // Active lines per frame
);
  import lpst_pkg::*;
  logic        pc = 0, ph = 0, pd = 0, pv = 0, syn = 0;
  int          run = 0, ln = 0;
  logic [23:0] q[$];
  always @(posedge clk) begin
    pc <= panel.pclk;
    // Sample away from the launch edge
    if (pc !== panel.pclk && panel.pclk === inv) begin
      if (panel.dataEn) q.push_back(panel.data);
      if (panel.vsync && !pv) lines = ln;
      if (panel.vsync && !pv) ln = 0;
      if (panel.dataEn && !pd) ln++;
      if (panel.hsync !== ph || panel.dataEn !== pd) begin
        if (ph) hsW = run;
        if (pd) deW = run;
        if (panel.dataEn && !ph && !pd && syn) frW = run;
        if (panel.hsync && !ph && !pd && !syn) bkW = run;
        if (ph || pd) syn = ph;
        run = 1;
      end else run++;
      ph = panel.hsync;
      pd = panel.dataEn;
      pv = panel.vsync;
    end
  end
endmodule : lpst_panel_model
